//--- verilog/fcrd_fault_retry.v
// Fault response sequencer: delay, retry and latch-off with registers
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fcrd_defines.vh"

// What this block does
// - Retry field 1 to 6 gives that many restarts
// - All attempts failed: output stays off until cleared
// - Retry field all ones retries until stopped
// - Attempt starts spaced by delay times unit
// - Delay field times operation and retry spacing
// - Delay field decodes as power-of-two units
// - Unit length comes from its own register
// - Retry field zero: no restart, stay off
// - Delayed mode runs on, then retries if fault
// - Latched fault clears by listed clearing actions
module fcrd_fault_retry #(
   parameter UNIT_W = 16,
   parameter [UNIT_W-1:0] UNIT_RST = `FCRD_UNIT_NS / `FCRD_CLK_NS
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_reset,
   // Avalon-MM slave
   input wire [7:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [3:0] i_avs_byteenable,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   // Asynchronous pins
   input wire i_fault,
   input wire i_other_fault,
   input wire i_ctrl_pin,
   input wire i_bias_ok,
   // Power stage and interrupt
   output reg o_out_en,
   output wire o_irq
);

////////////////////////////////////////////////////////////////////////////
// State codes, one-hot
localparam [6:0] ST_OFF = 7'h01;
localparam [6:0] ST_RUN = 7'h02;
localparam [6:0] ST_HOLD = 7'h04;
localparam [6:0] ST_DIS = 7'h08;
localparam [6:0] ST_WAIT = 7'h10;
localparam [6:0] ST_TRY = 7'h20;
localparam [6:0] ST_LATCH = 7'h40;

////////////////////////////////////////////////////////////////////////////
// Declarations
wire [3:0] pins_s;
wire fault_s, other_s, pin_on_s, bias_s;
reg fault_d_r;
reg [7:0] resp_r;
reg [UNIT_W-1:0] unit_r;
reg op_on_r;
reg [`FCRD_EV_W-1:0] status_r, status_nxt;
reg [`FCRD_EV_W-1:0] mask_r;
reg [7:0] count_r;
reg ack_r;
wire acc, wr_go, clr_cmd, clr_latch, enable;
wire [7:0] wr_b0;
reg [6:0] state_r, state_nxt;
reg [2:0] tries_r, tries_nxt;
reg fail_r, fail_nxt;
reg tmr_start;
reg [`FCRD_EV_W-1:0] ev;
wire tmr_done;
wire [2:0] dly_f, try_f;
wire [1:0] mode_f;

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; pins come from outside the clock domain
fcrd_sync #(
   .W(4),
   .RST(4'h0)
) u_sync (
   .i_ref_clk(i_ref_clk),
   .i_reset(i_reset),
   .i_async({i_bias_ok, i_ctrl_pin, i_other_fault, i_fault}),
   .o_sync(pins_s)
);

assign fault_s = pins_s[0];
assign other_s = pins_s[1];
assign pin_on_s = pins_s[2];
assign bias_s = pins_s[3];

// Fields of the fault response byte
assign dly_f = resp_r[`FCRD_DLY_F];
assign try_f = resp_r[`FCRD_TRY_F];
assign mode_f = resp_r[`FCRD_MODE_F];

////////////////////////////////////////////////////////////////////////////
// Delay timer, shared by run-on time and retry spacing
fcrd_delay_timer #(
   .UNIT_W(UNIT_W),
   .CNT_W(8)
) u_timer (
   .i_ref_clk(i_ref_clk),
   .i_reset(i_reset),
   .i_start(tmr_start),
   .i_unit(unit_r),
   .i_field(dly_f),
   .o_done(tmr_done),
   .o_busy()
);

////////////////////////////////////////////////////////////////////////////
// Bus handshake: every access waits exactly one cycle
assign acc = (i_avs_read | i_avs_write) & ~ack_r;
assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
// Writes land on the edge where waitrequest is seen low
assign wr_go = i_avs_write & ack_r;
assign wr_b0 = i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00;

// Clearing strobes from software
assign clr_cmd = wr_go & (i_avs_address == `FCRD_OFS_CTRL) &
   wr_b0[`FCRD_CTRL_CLR];
assign clr_latch = clr_cmd | (wr_go &
   (i_avs_address == `FCRD_OFS_STATUS) & wr_b0[`FCRD_EV_LATCH]);

// Output allowed only with bias, pin and command all on
assign enable = bias_s & pin_on_s & op_on_r;

always @(posedge i_ref_clk) begin
   if (i_reset) begin
      ack_r <= 1'b0;
   end else begin
      ack_r <= acc;
   end
end

////////////////////////////////////////////////////////////////////////////
// Read data captured at acceptance so it stands when waitrequest drops
always @(posedge i_ref_clk) begin
   if (i_reset) begin
      o_avs_readdata <= 32'h0000_0000;
   end else if (acc & i_avs_read) begin
      case (i_avs_address)
         `FCRD_OFS_RESP: o_avs_readdata <= {24'h00_0000, resp_r};
         `FCRD_OFS_UNIT: o_avs_readdata <= {{(32-UNIT_W){1'b0}}, unit_r};
         `FCRD_OFS_CTRL: o_avs_readdata <= {31'h0000_0000, op_on_r};
         `FCRD_OFS_STATUS: o_avs_readdata <= {28'h000_0000, status_r};
         `FCRD_OFS_MASK: o_avs_readdata <= {28'h000_0000, mask_r};
         `FCRD_OFS_STATE: o_avs_readdata <= {13'h0000, fault_s, tries_r,
            o_out_en, 7'h00, state_r};
         `FCRD_OFS_COUNT: o_avs_readdata <= {24'h00_0000, count_r};
         default: o_avs_readdata <= 32'h0000_0000;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// Software-written configuration
always @(posedge i_ref_clk) begin
   if (i_reset) begin
      resp_r <= `FCRD_RESP_RST;
      unit_r <= UNIT_RST;
      op_on_r <= `FCRD_CTRL_ON_RST;
      mask_r <= {`FCRD_EV_W{1'b0}};
   end else if (wr_go) begin
      case (i_avs_address)
         `FCRD_OFS_RESP: begin
            if (i_avs_byteenable[0]) begin
               resp_r <= i_avs_writedata[7:0];
            end
         end
         `FCRD_OFS_UNIT: begin
            if (i_avs_byteenable[0]) begin
               unit_r[7:0] <= i_avs_writedata[7:0];
            end
            if (i_avs_byteenable[1]) begin
               unit_r[UNIT_W-1:8] <= i_avs_writedata[UNIT_W-1:8];
            end
         end
         `FCRD_OFS_CTRL: begin
            if (i_avs_byteenable[0]) begin
               op_on_r <= i_avs_writedata[`FCRD_CTRL_ON];
            end
         end
         `FCRD_OFS_MASK: begin
            if (i_avs_byteenable[0]) begin
               mask_r <= i_avs_writedata[`FCRD_EV_W-1:0];
            end
         end
         default: mask_r <= mask_r;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// Sequencer next state; a fault shutdown goes to the retry path, latches, or in disable mode waits in ST_DIS
always @* begin
   state_nxt = state_r;
   tries_nxt = tries_r;
   fail_nxt = fail_r;
   tmr_start = 1'b0;
   ev = {`FCRD_EV_W{1'b0}};
   ev[`FCRD_EV_FAULT] = fault_s & ~fault_d_r;
   if (!enable && state_r != ST_OFF) begin
      // Commanded off or bias lost: stop and forget the fault
      state_nxt = ST_OFF;
   end else if (other_s && state_r != ST_OFF &&
      state_r != ST_LATCH) begin
      // A different fault forces shutdown, even mid retry
      state_nxt = ST_LATCH;
      ev[`FCRD_EV_LATCH] = 1'b1;
   end else begin
      case (state_r)
         ST_OFF: begin
            // Off then on again clears any latched fault
            if (enable) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (fault_s) begin
               case (mode_f)
                  `FCRD_MODE_DELAY: begin
                     state_nxt = ST_HOLD;
                     tmr_start = 1'b1;
                  end
                  `FCRD_MODE_RETRY: begin
                     if (try_f == `FCRD_TRY_NONE) begin
                        state_nxt = ST_LATCH;
                        ev[`FCRD_EV_LATCH] = 1'b1;
                     end else begin
                        state_nxt = ST_WAIT;
                        tries_nxt = try_f;
                        tmr_start = 1'b1;
                     end
                  end
                  `FCRD_MODE_DISABLE: begin
                     state_nxt = ST_DIS;
                  end
                  default: begin
                     state_nxt = ST_RUN;
                  end
               endcase
            end
         end
         ST_HOLD: begin
            // Keep running for the delay, then judge the fault
            if (tmr_done) begin
               if (!fault_s) begin
                  state_nxt = ST_RUN;
               end else if (try_f == `FCRD_TRY_NONE) begin
                  state_nxt = ST_LATCH;
                  ev[`FCRD_EV_LATCH] = 1'b1;
               end else begin
                  state_nxt = ST_WAIT;
                  tries_nxt = try_f;
                  tmr_start = 1'b1;
               end
            end
         end
         ST_DIS: begin
            // Off only while the fault stands
            if (!fault_s) begin
               state_nxt = ST_RUN;
            end
         end
         ST_WAIT: begin
            // Output off for one interval before the first attempt
            if (tmr_done) begin
               state_nxt = ST_TRY;
               tmr_start = 1'b1;
               fail_nxt = 1'b0;
               ev[`FCRD_EV_TRY] = 1'b1;
               if (tries_r != `FCRD_TRY_LOOP) begin
                  tries_nxt = tries_r - 3'h1;
               end
            end
         end
         ST_TRY: begin
            // A fault inside the attempt turns the output off at once
            if (fault_s) begin
               fail_nxt = 1'b1;
            end
            if (tmr_done) begin
               if (!(fail_r | fault_s)) begin
                  state_nxt = ST_RUN;
                  ev[`FCRD_EV_OK] = 1'b1;
               end else if (tries_r == `FCRD_TRY_LOOP ||
                  tries_r != `FCRD_TRY_NONE) begin
                  // Next attempt starts one interval after the last
                  tmr_start = 1'b1;
                  fail_nxt = 1'b0;
                  ev[`FCRD_EV_TRY] = 1'b1;
                  if (tries_r != `FCRD_TRY_LOOP) begin
                     tries_nxt = tries_r - 3'h1;
                  end
               end else begin
                  state_nxt = ST_LATCH;
                  ev[`FCRD_EV_LATCH] = 1'b1;
               end
            end
         end
         ST_LATCH: begin
            // Stays off until software clears it or enable drops and sends it to ST_OFF
            if (clr_latch) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_OFF;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// Sequencer registers and output enable
always @(posedge i_ref_clk) begin
   if (i_reset) begin
      state_r <= ST_OFF;
      tries_r <= 3'h0;
      fail_r <= 1'b0;
      fault_d_r <= 1'b0;
      o_out_en <= 1'b0;
      count_r <= 8'h00;
   end else begin
      state_r <= state_nxt;
      tries_r <= tries_nxt;
      fail_r <= fail_nxt;
      fault_d_r <= fault_s;
      o_out_en <= (state_nxt == ST_RUN) | (state_nxt == ST_HOLD) |
         ((state_nxt == ST_TRY) & ~fail_nxt);
      // Attempt counter saturates rather than wraps
      if (ev[`FCRD_EV_TRY] && count_r != 8'hff) begin
         count_r <= count_r + 8'h01;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Sticky status; a new event wins over a clear in the same cycle
always @* begin
   status_nxt = status_r;
   if (wr_go && i_avs_address == `FCRD_OFS_STATUS) begin
      status_nxt = status_r & ~wr_b0[`FCRD_EV_W-1:0];
   end
   if (clr_cmd) begin
      status_nxt = {`FCRD_EV_W{1'b0}};
   end
   status_nxt = status_nxt | ev;
end

always @(posedge i_ref_clk) begin
   if (i_reset) begin
      status_r <= {`FCRD_EV_W{1'b0}};
   end else begin
      status_r <= status_nxt;
   end
end

// Level interrupt while any unmasked status bit is set
assign o_irq = |(status_r & mask_r);

endmodule
`default_nettype wire

//--- verilog/fcrd_defines.vh
// Register map, field layout and timing constants of the fault retry block
`ifndef FCRD_DEFINES_VH
`define FCRD_DEFINES_VH

// Clock period and default length of one delay time unit
`define FCRD_CLK_NS 8
`define FCRD_UNIT_NS 1000

// Byte offsets of the registers, one aligned word each
`define FCRD_OFS_RESP 8'h00
`define FCRD_OFS_UNIT 8'h04
`define FCRD_OFS_CTRL 8'h08
`define FCRD_OFS_STATUS 8'h0c
`define FCRD_OFS_MASK 8'h10
`define FCRD_OFS_STATE 8'h14
`define FCRD_OFS_COUNT 8'h18

// Fault response byte: delay count, retry count, response mode
`define FCRD_DLY_F 2:0
`define FCRD_TRY_F 5:3
`define FCRD_MODE_F 7:6
`define FCRD_RESP_RST 8'h80
`define FCRD_TRY_NONE 3'h0
`define FCRD_TRY_LOOP 3'h7
`define FCRD_MODE_IGNORE 2'h0
`define FCRD_MODE_DELAY 2'h1
`define FCRD_MODE_RETRY 2'h2
`define FCRD_MODE_DISABLE 2'h3

// Control register: output on command, clear faults strobe
`define FCRD_CTRL_ON 0
`define FCRD_CTRL_CLR 1
`define FCRD_CTRL_ON_RST 1'h1

// Event bits shared by status and mask
`define FCRD_EV_W 4
`define FCRD_EV_FAULT 0
`define FCRD_EV_TRY 1
`define FCRD_EV_LATCH 2
`define FCRD_EV_OK 3

`endif

//--- verilog/fcrd_sync.v
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module fcrd_sync #(
   parameter W = 4,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_reset,
   // Levels in and out
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;

// First stage feeds only the second stage
always @(posedge i_ref_clk) begin
   if (i_reset) begin
      meta_r <= RST;
      sync_r <= RST;
   end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
   end
end

assign o_sync = sync_r;

endmodule
`default_nettype wire

//--- verilog/fcrd_delay_timer.v
// Delay timer: power-of-two count of programmable time units
`timescale 1ns/1ps
`default_nettype none

module fcrd_delay_timer #(
   parameter UNIT_W = 16,
   parameter CNT_W = 8
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_reset,
   // Start strobe, unit length in cycles, delay field
   input wire i_start,
   input wire [UNIT_W-1:0] i_unit,
   input wire [2:0] i_field,
   // Expiry pulse and busy level
   output wire o_done,
   output wire o_busy
);

reg [UNIT_W-1:0] pre_r;
reg [CNT_W-1:0] units_r;
reg busy_r;
reg done_r;
wire tick;

// Field n means 2**n units, so field 2 gives 4
function [CNT_W-1:0] units_of;
   input [2:0] f;
   begin
      units_of = {{(CNT_W-1){1'b0}}, 1'b1} << f;
   end
endfunction

// A unit length of zero is treated as one cycle
assign tick = (pre_r == i_unit - 1'b1) | (i_unit == {UNIT_W{1'b0}});

// Prescaler counts cycles of a unit, then units count down
always @(posedge i_ref_clk) begin
   if (i_reset) begin
      pre_r <= {UNIT_W{1'b0}};
      units_r <= {CNT_W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
   end else begin
      done_r <= 1'b0;
      if (i_start) begin
         pre_r <= {UNIT_W{1'b0}};
         units_r <= units_of(i_field) - 1'b1;
         busy_r <= 1'b1;
      end else if (busy_r) begin
         if (tick) begin
            pre_r <= {UNIT_W{1'b0}};
            if (units_r == {CNT_W{1'b0}}) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               units_r <= units_r - 1'b1;
            end
         end else begin
            pre_r <= pre_r + 1'b1;
         end
      end
   end
end

assign o_done = done_r;
assign o_busy = busy_r;

endmodule
`default_nettype wire

//--- verification/fcrd_fault_retry_sva.sv
// Checker of bus handshake and output shut-off for the fault retry block
`timescale 1ns/1ps
`default_nettype none
module fcrd_fault_retry_chk (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_reset,
   // Bus seen at the top
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   // Pins and outputs
   input wire i_other_fault,
   input wire i_ctrl_pin,
   input wire i_bias_ok,
   input wire o_out_en,
   input wire o_irq
);
   // One clock domain, reset disables all but the release check
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   property p_wait_rise;
      $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest;
   endproperty
   a_wait_rise: assert property (p_wait_rise) else $error("no wait");
   property p_wait_one;
      (i_avs_read | i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("long wait");
   property p_wait_req;
      o_avs_waitrequest |-> i_avs_read | i_avs_write;
   endproperty
   a_wait_req: assert property (p_wait_req) else $error("stray wait");
   property p_rd_hold;
      !i_avs_read |=> $stable(o_avs_readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
   // Checked on release, so reset must not disable it
   property p_rst_quiet;
      disable iff (1'b0)
      $fell(i_reset) |-> !o_out_en && !o_irq && o_avs_readdata == 32'h0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("reset");
   // Six cycles cover two sync stages, state and output register
   property p_pin_off;
      (!i_ctrl_pin) [*6] |-> !o_out_en;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin off");
   property p_bias_off;
      (!i_bias_ok) [*6] |-> !o_out_en;
   endproperty
   a_bias_off: assert property (p_bias_off) else $error("bias");
   property p_other_off;
      i_other_fault [*6] |-> !o_out_en;
   endproperty
   a_other_off: assert property (p_other_off) else $error("other");
endmodule
bind fcrd_fault_retry fcrd_fault_retry_chk u_chk (
   .i_ref_clk(i_ref_clk),
   .i_reset(i_reset),
   .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write),
   .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest),
   .i_other_fault(i_other_fault),
   .i_ctrl_pin(i_ctrl_pin),
   .i_bias_ok(i_bias_ok),
   .o_out_en(o_out_en),
   .o_irq(o_irq)
);
`default_nettype wire

//--- verification/fcrd_stage_model.sv
// Power stage model that can short its load
`timescale 1ns/1ps
`default_nettype none
module fcrd_stage_model (
   // Enable from the device and short request
   input wire i_out_en,
   input wire i_short,
   // Fault level back to the device
   output wire o_fault
);
   // A short only shows while power flows, so every restart fails
   assign o_fault = i_short & i_out_en;
endmodule
`default_nettype wire

//--- verification/tb_fault_retry_delay_control.sv
// Self-checking bench of the fault retry block
`timescale 1ns/1ps
`default_nettype none
`include "fcrd_defines.vh"
module tb_fault_retry_delay_control;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] adr = 8'h0;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg [31:0] wd = 32'h0;
   reg oflt = 1'b0;
   reg pin = 1'b1;
   reg bias = 1'b1;
   reg shrt = 1'b0;
   reg oen_d = 1'b0;
   reg [31:0] d;
   wire [31:0] rdat;
   wire wreq;
   wire flt;
   wire oen;
   wire irq;
   integer fails = 0;
   integer n_tests = 0;
   integer seed = 32'hba71;
   integer cyc = 0;
   integer tot = 0;
   integer unit;
   integer k;
   integer i;
   integer j;
   integer t;
   integer rq[$];
   integer tk[0:3] = '{0, 3, 2, 6};
   localparam UNIT0 = 3;
   // Device and the stage it powers; byte lanes stay all on
   fcrd_fault_retry #(.UNIT_RST(16'h0003)) u_dut (
      .i_ref_clk(clk), .i_reset(rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hf),
      .i_avs_writedata(wd), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_fault(flt), .i_other_fault(oflt),
      .i_ctrl_pin(pin), .i_bias_ok(bias), .o_out_en(oen), .o_irq(irq));
   fcrd_stage_model u_stage (.i_out_en(oen), .i_short(shrt), .o_fault(flt));
   // Clock of 8 ns
   always #4 clk = ~clk;
   // Rising edges of the output are the attempt start times
   always @(posedge clk) begin
      cyc <= cyc + 1;
      oen_d <= oen;
      if (oen && !oen_d) begin
         rq.push_back(cyc);
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk_near(input integer got, input integer lo, input integer hi);
      begin
         n_tests = n_tests + 1;
         if (got < lo || got > hi) begin
            fails = fails + 1;
            $display("Error at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
         end
      end
   endtask
   // Request stands until waitrequest is sampled low at a rising edge;
   // read data is taken at that edge, then the request drops
   task bus(input w, input [7:0] a, input [31:0] v);
      begin
         adr <= a;
         wd <= v;
         wr <= w;
         rd <= !w;
         @(posedge clk);
         while (wreq !== 1'b0) begin
            @(posedge clk);
         end
         d = rdat;
         wr <= 1'b0;
         rd <= 1'b0;
         @(posedge clk);
      end
   endtask
   task wait_latch;
      integer n;
      begin
         n = 0;
         d = 32'h0;
         while (d[6] !== 1'b1 && n < 300) begin
            bus(1'b0, `FCRD_OFS_STATE, 32'h0);
            n = n + 1;
         end
      end
   endtask
   task end_of_test;
      begin
         $display("Comparisons %0d, mismatches %0d", n_tests, fails);
         if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask
   // Watchdog well beyond the expected run
   initial begin
      #(8 * 60000);
      fails = fails + 1;
      end_of_test;
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, `FCRD_OFS_RESP, 32'h0);
      chk(d, {24'h0, `FCRD_RESP_RST});
      bus(1'b0, `FCRD_OFS_UNIT, 32'h0);
      chk(d, UNIT0);
      bus(1'b0, `FCRD_OFS_MASK, 32'h0);
      chk(d, 32'h0);
      bus(1'b0, 8'h1c, 32'h0);
      chk(d, 32'h0);
      bus(1'b1, `FCRD_OFS_MASK, 32'h4);
      // Retry counts with a persistent short, spacing per delay field
      for (i = 0; i < 4; i = i + 1) begin
         unit = 1 + ({$random(seed)} % 4);
         k = tk[i];
         bus(1'b1, `FCRD_OFS_UNIT, unit);
         bus(1'b1, `FCRD_OFS_RESP, {`FCRD_MODE_RETRY, k[2:0], i[2:0]});
         chk(oen, 1'b1);
         rq.delete();
         shrt <= 1'b1;
         wait_latch();
         chk(d[6:0], 7'h40);
         repeat (4 * (unit << i) + 8) @(posedge clk);
         chk(oen, 1'b0);
         chk(irq, 1'b1);
         chk(rq.size(), k);
         for (j = 1; j < rq.size(); j = j + 1) begin
            chk_near(rq[j] - rq[j-1], unit << i, (unit << i) + 3);
         end
         tot = tot + k;
         bus(1'b0, `FCRD_OFS_COUNT, 32'h0);
         chk(d[7:0], tot);
         shrt <= 1'b0;
         if (i % 2) bus(1'b1, `FCRD_OFS_CTRL, 32'h3);
         else bus(1'b1, `FCRD_OFS_STATUS, 32'h4);
         chk(irq, 1'b0);
         repeat (6) @(posedge clk);
      end
      // Endless retrying until the pin turns the output off
      bus(1'b1, `FCRD_OFS_RESP, {`FCRD_MODE_RETRY, `FCRD_TRY_LOOP, 3'h0});
      rq.delete();
      shrt <= 1'b1;
      repeat (200) @(posedge clk);
      chk_near(rq.size(), 200 / (unit + 5), 200);
      pin <= 1'b0;
      repeat (8) @(posedge clk);
      rq.delete();
      repeat (50) @(posedge clk);
      chk(rq.size(), 0);
      shrt <= 1'b0;
      pin <= 1'b1;
      repeat (10) @(posedge clk);
      chk(oen, 1'b1);
      // Another fault latches off; bias loss then reset clear it
      oflt <= 1'b1;
      repeat (8) @(posedge clk);
      oflt <= 1'b0;
      repeat (20) @(posedge clk);
      chk(oen, 1'b0);
      bias <= 1'b0;
      repeat (10) @(posedge clk);
      bias <= 1'b1;
      repeat (10) @(posedge clk);
      chk(oen, 1'b1);
      oflt <= 1'b1;
      repeat (8) @(posedge clk);
      oflt <= 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      chk(oen, 1'b1);
      // Delayed mode runs on for one interval before shutting down
      bus(1'b1, `FCRD_OFS_UNIT, 32'h2);
      bus(1'b1, `FCRD_OFS_RESP, {`FCRD_MODE_DELAY, 3'h1, 3'h3});
      shrt <= 1'b1;
      t = 0;
      @(posedge clk);
      while (oen === 1'b1 && t < 100) begin
         @(posedge clk);
         t = t + 1;
      end
      chk_near(t, 16, 21);
      wait_latch();
      chk(d[6:0], 7'h40);
      // Ignore mode runs through a short; disable mode cycles with it
      shrt <= 1'b0;
      bus(1'b1, `FCRD_OFS_CTRL, 32'h3);
      bus(1'b1, `FCRD_OFS_RESP, {`FCRD_MODE_IGNORE, 6'h00});
      rq.delete();
      shrt <= 1'b1;
      repeat (40) @(posedge clk);
      chk(oen, 1'b1);
      chk(rq.size(), 0);
      bus(1'b1, `FCRD_OFS_RESP, {`FCRD_MODE_DISABLE, 6'h00});
      repeat (40) @(posedge clk);
      chk_near(rq.size(), 3, 20);
      end_of_test;
   end
endmodule
`default_nettype wire
